// [rtl/drr_src_end.sv]
`timescale 1ns/10ps
`include "drr_map.svh"
module drr_src_end (
    input wire logic CLK_I,
    input wire logic NRST_I,
    drr_if.src LINK,
    input wire logic [31:0] CMD_RPID_I,
    input wire logic [31:0] XFER_LEN_I,
    input wire logic [7:0] CMD_PORT_I,
    input wire logic [31:0] CMD_PATH_I,
    input wire logic LAST_BYTE_I,
    input wire logic [7:0] DATA_I,
    output logic DATA_TAKE_O,
    output logic ALERT_O,
    output logic RESP_O,
    output logic [1:0] ERR_CODE_O,
    output logic [15:0] TAG_O,
    output logic ACTIVE_O
);
    import drr_pkg::*;
    // intake, one cycle of checking, then data out
    typedef enum logic [1:0] {S_RX, S_CHK, S_SEND} drr_state_t;
    // whole state of the source end
    typedef struct packed {
        drr_state_t st;
        logic [167:0] sh;
        logic [4:0] n;
        drr_msg_t m;
        logic [31:0] left;
        logic alert;
        logic resp;
        logic [1:0] err;
        logic [15:0] tag;
    } drr_src_st_t;
    // registered state and its next value
    drr_src_st_t st_r, st_nxt;
    drr_word_t w; // word offered to the buffer
    logic b_ready, b_valid; // buffer handshake on the push side
    drr_msg_t pm; // message as parsed in the check cycle
    logic is_req, is_rdr; // code and length agree
    logic ofs_bad, cnt_bad, sum_bad, rpid_bad; // single field faults
    // modulo-eight check, used for offset and count
    function automatic logic mod8_bad(input logic [31:0] v);
        mod8_bad = ((v & `DRR_MOD8_MASK) != 32'h0);
    endfunction
    // unpack the shifted image into fields
    function automatic drr_msg_t unpack(input logic [167:0] s, input logic [4:0] n);
        logic [167:0] a;
        a = (n == `DRR_LEN_REQ) ? {s[111:0], 56'h0} : s;
        // the reserved second byte has no field, so it is cut out here
        unpack = {a[167:160], a[151:0]};
    endfunction
    // the buffer holds two words so a receiver stall loses none
    drr_buf u_buf (
        .CLK_I(CLK_I),
        .NRST_I(NRST_I),
        .in_valid_i(b_valid),
        .in_ready_o(b_ready),
        .in_word_i(w),
        .out_valid_o(LINK.dat_valid),
        .out_ready_i(LINK.dat_ready),
        .out_word_o(LINK.dat_word)
    );
    // ready only in intake; a message that arrives mid-transfer waits on the link
    assign LINK.msg_ready = (st_r.st == S_RX);
    assign b_valid = (st_r.st == S_SEND);
    // the data source steps on exactly when a word enters the buffer
    assign DATA_TAKE_O = b_valid && b_ready;
    // status outputs come straight from flip-flops, except ACTIVE_O, which is decoded from the state
    assign ALERT_O = st_r.alert;
    assign RESP_O = st_r.resp;
    assign ERR_CODE_O = st_r.err;
    assign TAG_O = st_r.tag;
    assign ACTIVE_O = (st_r.st == S_SEND);
    // field checks of the message held in the shifter
    always_comb begin
        pm = unpack(st_r.sh, st_r.n);
        is_req = (st_r.n == `DRR_LEN_REQ) && (pm.code == `DRR_CODE_REQ);
        is_rdr = (st_r.n == `DRR_LEN_RDR) && (pm.code == `DRR_CODE_RDR);
        ofs_bad = mod8_bad(pm.ofs_rpid);
        // a count off the eight grid is only legal when it carries the final byte
        cnt_bad = mod8_bad(pm.cnt) && !LAST_BYTE_I;
        // one bit wider so that a huge offset cannot wrap below the limit
        sum_bad = ({1'b0, pm.ofs_rpid} + {1'b0, pm.cnt}) > {1'b0, XFER_LEN_I};
        rpid_bad = (pm.ofs_rpid != CMD_RPID_I);
    end
    // data word address: redirect uses out path and port
    always_comb begin
        w.data = DATA_I;
        w.last = (st_r.left == 32'h1);
        // channel always comes from the message
        w.chan = st_r.m.chan;
        if (st_r.m.code == `DRR_CODE_RDR) begin
            // redirect: out path and port from the message
            w.path = st_r.m.opath;
            w.port = st_r.m.oport;
        end else begin
            // plain request: the command's own path and port
            w.path = CMD_PATH_I;
            w.port = CMD_PORT_I;
        end
    end
    // message intake, check and transfer sequencing
    always_comb begin
        st_nxt = st_r;
        // alert and response are one-cycle pulses
        st_nxt.alert = 1'b0;
        st_nxt.resp = 1'b0;
        case (st_r.st)
            S_RX: begin
                // bytes come most significant first and shift in at the bottom
                if (LINK.msg_valid) begin
                    st_nxt.sh = {st_r.sh[159:0], LINK.msg_byte};
                    // the count saturates, so an overlong message cannot wrap onto a valid length
                    if (st_r.n != 5'h1F) begin
                        st_nxt.n = st_r.n + 5'h1;
                    end
                    if (LINK.msg_last) begin
                        st_nxt.st = S_CHK;
                    end
                end
            end
            S_CHK: begin
                // one message at a time: the next waits until this transfer ends
                st_nxt.m = pm;
                st_nxt.tag = pm.tag;
                st_nxt.left = pm.cnt;
                st_nxt.n = 5'h0;
                st_nxt.sh = '0;
                st_nxt.st = S_RX;
                st_nxt.err = `DRR_ERR_NONE;
                if (is_req) begin
                    // plain request: every field fault, the optional sum too, gets a response
                    if (ofs_bad || cnt_bad || sum_bad) begin
                        st_nxt.err = `DRR_ERR_FIELD;
                        st_nxt.resp = 1'b1;
                    end else if (pm.cnt != 32'h0) begin
                        st_nxt.st = S_SEND;
                    end
                end else if (is_rdr) begin
                    // return path goes first: a foreign sender gets an alert, not a response
                    if (rpid_bad) begin
                        st_nxt.err = `DRR_ERR_RPID;
                        st_nxt.alert = 1'b1;
                    end else if (cnt_bad) begin
                        st_nxt.err = `DRR_ERR_FIELD;
                        st_nxt.resp = 1'b1;
                    end else if (pm.cnt != 32'h0) begin
                        // a zero count moves nothing and leaves the requester waiting
                        st_nxt.st = S_SEND;
                    end
                end else begin
                    // unknown code, or a length that does not fit the code
                    st_nxt.err = `DRR_ERR_UNEXP;
                    st_nxt.alert = 1'b1;
                end
                // a rejection only drops the message, nothing else is torn down
            end
            S_SEND: begin
                // whole transfer finishes before the next message is taken
                // the buffer absorbs a receiver stall, so every pushed word is delivered
                if (b_ready) begin
                    st_nxt.left = st_r.left - 32'h1;
                    // the word with last set closes the message
                    if (st_r.left == 32'h1) begin
                        st_nxt.st = S_RX;
                    end
                end
            end
            default: begin
                // unused encoding, back to intake
                st_nxt.st = S_RX;
            end
        endcase
    end
    // state register
    // async clear leaves the end in intake with nothing in flight
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// [rtl/drr_map.svh]
`ifndef DRR_MAP_SVH
`define DRR_MAP_SVH
// message codes
`define DRR_CODE_REQ 8'h22
`define DRR_CODE_RDR 8'h23
// byte positions, most significant byte first
`define DRR_B_CODE 0
`define DRR_B_TAG 2
`define DRR_B_OFS 4
`define DRR_B_RPID 4
`define DRR_B_CNT 8
`define DRR_B_CHAN 12
`define DRR_B_XID 14
`define DRR_B_OPATH 16
`define DRR_B_OPORT 20
// message lengths in bytes
`define DRR_LEN_REQ 5'h0E
`define DRR_LEN_RDR 5'h15
// modulo-eight mask
`define DRR_MOD8_MASK 32'h00000007
// error codes reported upward
`define DRR_ERR_NONE 2'h0
`define DRR_ERR_RPID 2'h1
`define DRR_ERR_FIELD 2'h2
`define DRR_ERR_UNEXP 2'h3
// buffer depth
`define DRR_BUF_DEPTH 2
`endif

// [rtl/drr_pkg.sv]
package drr_pkg;
    // one parsed message, both kinds share the layout
    typedef struct packed {
        logic [7:0] code;
        logic [15:0] tag;
        logic [31:0] ofs_rpid;
        logic [31:0] cnt;
        logic [15:0] chan;
        logic [15:0] xid;
        logic [31:0] opath;
        logic [7:0] oport;
    } drr_msg_t;
    // one outgoing data word with its frame address
    typedef struct packed {
        logic [31:0] path;
        logic [15:0] chan;
        logic [7:0] port;
        logic [7:0] data;
        logic last;
    } drr_word_t;
endpackage

// [rtl/drr_if.sv]
`timescale 1ns/10ps
interface drr_if;
    import drr_pkg::*;
    // message byte stream, requester to data source
    logic msg_valid;
    logic msg_ready;
    logic [7:0] msg_byte;
    logic msg_last;
    // data stream, source to receiver
    logic dat_valid;
    logic dat_ready;
    drr_word_t dat_word;
    modport src (input msg_valid, msg_byte, msg_last, dat_ready, output msg_ready, dat_valid, dat_word);
    modport req (output msg_valid, msg_byte, msg_last, dat_ready, input msg_ready, dat_valid, dat_word);
endinterface

// [rtl/drr_buf.sv]
`timescale 1ns/10ps
`include "drr_map.svh"
module drr_buf (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire drr_pkg::drr_word_t in_word_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output drr_pkg::drr_word_t out_word_o
);
    import drr_pkg::*;
    // two words plus pointers and fill level
    typedef struct packed {
        drr_word_t [1:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } drr_buf_st_t;
    drr_buf_st_t st_r, st_nxt;
    logic push, pop;
    // honest full and empty straight from the count
    assign in_ready_o = (st_r.cnt != 2'(`DRR_BUF_DEPTH));
    assign out_valid_o = (st_r.cnt != 2'h0);
    assign out_word_o = st_r.mem[st_r.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    // next state
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_word_i;
            st_nxt.wp = ~st_r.wp;
        end
        if (pop) begin
            st_nxt.rp = ~st_r.rp;
        end
        st_nxt.cnt = st_r.cnt + 2'(push) - 2'(pop);
    end
    // state register
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// [rtl/drr_req_end.sv]
`timescale 1ns/10ps
`include "drr_map.svh"
module drr_req_end (
    input wire logic CLK_I,
    input wire logic NRST_I,
    drr_if.req LINK,
    input wire logic SEND_I,
    input wire logic REDIR_I,
    input wire drr_pkg::drr_msg_t MSG_I,
    output logic BUSY_O,
    output logic [7:0] RX_DATA_O,
    output logic RX_VALID_O,
    output logic RX_LAST_O
);
    import drr_pkg::*;
    // serialiser state and outstanding flag
    typedef struct packed {
        logic [167:0] sh;
        logic [4:0] left;
        logic out;
        logic [7:0] rx_d;
        logic rx_v;
        logic rx_l;
    } drr_req_st_t;
    drr_req_st_t st_r, st_nxt;
    logic [167:0] img;
    // pack fields most significant byte first
    always_comb begin
        img = {MSG_I.code, 8'h00, MSG_I.tag, MSG_I.ofs_rpid, MSG_I.cnt, MSG_I.chan,
               MSG_I.xid, MSG_I.opath, MSG_I.oport};
        if (!REDIR_I) begin
            img[7:0] = 8'h00;
        end
    end
    assign LINK.msg_valid = (st_r.left != 5'h0);
    assign LINK.msg_byte = st_r.sh[167:160];
    assign LINK.msg_last = (st_r.left == 5'h1);
    assign LINK.dat_ready = 1'b1;
    assign BUSY_O = st_r.out || (st_r.left != 5'h0);
    assign RX_DATA_O = st_r.rx_d;
    assign RX_VALID_O = st_r.rx_v;
    assign RX_LAST_O = st_r.rx_l;
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.rx_v = LINK.dat_valid;
        st_nxt.rx_l = LINK.dat_valid && LINK.dat_word.last;
        if (LINK.dat_valid) begin
            st_nxt.rx_d = LINK.dat_word.data;
        end
        // outstanding ends with last data frame
        if (LINK.dat_valid && LINK.dat_word.last) begin
            st_nxt.out = 1'b0;
        end
        if (LINK.msg_valid && LINK.msg_ready) begin
            st_nxt.sh = {st_r.sh[159:0], 8'h00};
            st_nxt.left = st_r.left - 5'h1;
        end
        // only one outstanding at a time keeps the issue rule simple
        if (SEND_I && !BUSY_O) begin
            st_nxt.sh = img;
            st_nxt.left = REDIR_I ? `DRR_LEN_RDR : `DRR_LEN_REQ;
            st_nxt.out = 1'b1;
        end
    end
    // state register
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// [sim/drr_link_asserts.sv]
`timescale 1ns/10ps
`include "drr_map.svh"
// watches the link between the two ends
module drr_link_asserts (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic msg_valid,
    input wire logic msg_ready,
    input wire logic [7:0] msg_byte,
    input wire logic msg_last,
    input wire logic dat_valid,
    input wire logic dat_ready,
    input wire drr_pkg::drr_word_t dat_word
);
    import drr_pkg::*;
    logic first_r; // next byte opens a message
    logic dfirst_r; // next word opens a data run
    logic [4:0] idx_r; // byte position in message
    logic [7:0] code_r; // code of message in flight
    logic [55:0] adr_r; // frame address of last word
    // framing tracker; assumes the sender never aborts mid-message
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            first_r <= 1'b1;
            dfirst_r <= 1'b1;
            idx_r <= 5'h00;
            code_r <= 8'h00;
            adr_r <= 56'h0;
        end else begin
            if (msg_valid && msg_ready) begin
                first_r <= msg_last;
                idx_r <= msg_last ? 5'h00 : idx_r + 5'h01;
                code_r <= first_r ? msg_byte : code_r;
            end
            if (dat_valid && dat_ready) begin
                dfirst_r <= dat_word.last;
                adr_r <= {dat_word.path, dat_word.chan, dat_word.port};
            end
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    property p_msg_hold;
        msg_valid && !msg_ready |=> msg_valid && $stable(msg_byte) && $stable(msg_last);
    endproperty
    a_msg_hold: assert property (p_msg_hold) else $error("message byte dropped before taken");
    property p_code;
        msg_valid && first_r |-> msg_byte inside {`DRR_CODE_REQ, `DRR_CODE_RDR};
    endproperty
    a_code: assert property (p_code) else $error("bad message code");
    property p_len;
        msg_valid && msg_ready && msg_last |-> idx_r == (code_r == `DRR_CODE_REQ ? 5'h0D : 5'h14);
    endproperty
    a_len: assert property (p_len) else $error("bad message length");
    property p_check;
        msg_valid && msg_ready && msg_last |=> !msg_ready;
    endproperty
    a_check: assert property (p_check) else $error("byte taken during check");
    property p_gap;
        msg_valid && msg_ready && msg_last |=> !dat_valid [*2];
    endproperty
    a_gap: assert property (p_gap) else $error("data before message checked");
    property p_dat_hold;
        dat_valid && !dat_ready |=> dat_valid && $stable(dat_word);
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("data word dropped");
    property p_serial;
        dat_valid |-> !msg_valid;
    endproperty
    a_serial: assert property (p_serial) else $error("message while data pending");
    property p_last_ends;
        dat_valid && dat_ready && dat_word.last |=> !dat_valid;
    endproperty
    a_last_ends: assert property (p_last_ends) else $error("word after final word");
    property p_addr;
        dat_valid && !dfirst_r |-> {dat_word.path, dat_word.chan, dat_word.port} == adr_r;
    endproperty
    a_addr: assert property (p_addr) else $error("address changed in a run");
endmodule

// [sim/tb.sv]
`timescale 1ns/10ps
`include "drr_map.svh"
module tb;
    import drr_pkg::*;
    logic clk, nrst_src, nrst_req, send, redir, last_ok, took;
    logic [31:0] rpid, xlen, cpath;
    logic [7:0] cport, data_in, nb; // nb: next byte expected
    drr_msg_t msg;
    logic busy, rx_valid, rx_last, take, alert, resp, active;
    logic [7:0] rx_data;
    logic [1:0] err;
    logic [15:0] tag_o;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [63:0] exp_rx[$], exp_adr[$]; // notes for words and addresses
    logic [17:0] exp_err[$]; // notes for rejections
    logic [17:0] en; // oldest rejection note
    drr_if lnk();
    drr_req_end drr_req_end_i (.CLK_I(clk), .NRST_I(nrst_req), .LINK(lnk), .SEND_I(send), .REDIR_I(redir),
        .MSG_I(msg), .BUSY_O(busy), .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid), .RX_LAST_O(rx_last));
    drr_src_end drr_src_end_i (.CLK_I(clk), .NRST_I(nrst_src), .LINK(lnk), .CMD_RPID_I(rpid),
        .XFER_LEN_I(xlen), .CMD_PORT_I(cport), .CMD_PATH_I(cpath), .LAST_BYTE_I(last_ok),
        .DATA_I(data_in), .DATA_TAKE_O(take), .ALERT_O(alert), .RESP_O(resp), .ERR_CODE_O(err),
        .TAG_O(tag_o), .ACTIVE_O(active));
    drr_link_asserts drr_link_asserts_i (.CLK_I(clk), .NRST_I(nrst_src), .msg_valid(lnk.msg_valid),
        .msg_ready(lnk.msg_ready), .msg_byte(lnk.msg_byte), .msg_last(lnk.msg_last),
        .dat_valid(lnk.dat_valid), .dat_ready(lnk.dat_ready), .dat_word(lnk.dat_word));
    // clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic cmp_dat(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_err(input logic [17:0] got, input logic [17:0] exp);
        cmp_dat({46'h0, got}, {46'h0, exp});
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // send one message, note what should come back, wait for its end
    task automatic msg_go(input logic r, input logic [15:0] tg, input logic [31:0] op, input logic [31:0] c,
        input logic [15:0] ch, input logic [31:0] pa, input logic [7:0] pt, input logic [1:0] ee);
        int n, act;
        @(negedge clk);
        msg = '{r ? `DRR_CODE_RDR : `DRR_CODE_REQ, tg, op, c, ch, 16'($urandom), pa, pt};
        redir = r;
        send = 1'b1;
        if (ee != `DRR_ERR_NONE) exp_err.push_back({tg, ee});
        else for (n = 0; n < c; n++) begin
            exp_rx.push_back({55'h0, n == c - 1, nb});
            exp_adr.push_back(r ? {8'h0, pa, ch, pt} : {8'h0, cpath, ch, cport});
            nb++;
        end
        @(negedge clk);
        send = 1'b0;
        act = 0;
        // wait for the end or the rejection, counting the cycles spent sending
        for (n = 0; n < 400 && ((ee == 2'h0) ? busy : !(alert || resp)); n++) begin
            @(negedge clk);
            if (active) act++;
        end
        cmp_dat(64'(n == 400), 64'h0);
        cmp_dat(64'(act), (ee == 2'h0) ? 64'(c) : 64'h0);
        // a rejected message leaves the requester waiting, so only it is reset
        if (ee != 2'h0) nrst_req = 1'b0;
        @(negedge clk);
        nrst_req = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    // data source steps on after each word it gave away
    always @(negedge clk) begin
        if (took) data_in <= data_in + 8'h01;
        took <= take;
    end
    // result watcher, oldest note first
    always @(negedge clk) begin
        if (rx_valid) cmp_dat({55'h0, rx_last, rx_data}, exp_rx.size() ? exp_rx.pop_front() : 64'hX);
        if (lnk.dat_valid && lnk.dat_ready) cmp_dat({8'h0, lnk.dat_word.path, lnk.dat_word.chan,
            lnk.dat_word.port}, exp_adr.size() ? exp_adr.pop_front() : 64'hX);
        if (alert || resp) begin
            en = exp_err.size() ? exp_err.pop_front() : 18'hX;
            cmp_err({tag_o, err}, en);
            cmp_err({16'h0, alert, resp}, {16'h0, en[1:0] != `DRR_ERR_FIELD, en[1:0] == `DRR_ERR_FIELD});
        end
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
    initial begin
        {nrst_src, nrst_req, send, redir, last_ok, took} = 6'h00;
        msg = '0;
        void'($urandom(36065));
        rpid = $urandom;
        cpath = $urandom;
        cport = 8'($urandom);
        data_in = 8'($urandom);
        nb = data_in;
        xlen = 32'h00000040;
        repeat (12) @(posedge clk);
        @(negedge clk);
        nrst_src = 1'b1;
        nrst_req = 1'b1;
        // back to back traffic, same channel first
        for (int i = 0; i < 6; i++) msg_go(i[0], 16'($urandom), i[0] ? rpid : 32'h8 * (i / 2),
            32'h8 * (1 + $urandom % 3), i < 2 ? 16'h0005 : 16'($urandom), $urandom, 8'($urandom), 2'h0);
        $display("test 1 done");
        // end of transfer exactly, then a short final count
        msg_go(1'b0, 16'h0101, 32'h38, 32'h8, 16'h0002, cpath, cport, 2'h0);
        last_ok = 1'b1;
        msg_go(1'b0, 16'h0102, 32'h30, 32'hB, 16'h0002, cpath, cport, 2'h0);
        last_ok = 1'b0;
        $display("test 2 done");
        // four rejections, then one redirect with normal service
        for (int i = 0; i < 4; i++) msg_go(i < 2, 16'h0A00 + 16'(i), (i == 0) ? rpid ^ 32'h1 : (i == 1) ? rpid :
            (i == 2) ? 32'h4 : 32'h40, (i == 1) ? 32'hC : 32'h8, 16'h0003, cpath, cport,
            (i == 0) ? `DRR_ERR_RPID : `DRR_ERR_FIELD);
        msg_go(1'b1, 16'h0A04, rpid, 32'h10, 16'h0003, cpath, cport, 2'h0);
        $display("test 3 done");
        cmp_dat(64'(exp_rx.size() + exp_adr.size() + exp_err.size()), 64'h0);
        wrap_up();
    end
endmodule
